// ---- src/rsel_pkg.sv ----
/*
 * Package for the raw status and event latch bank: register indices,
 * field positions, widths and the carrier structs for the source signals.
 * Assumes a Wishbone classic slave with 32-bit data and word addressing.
 */
package rsel_pkg;

    // ********************************************************
    // Register indices (byte address is four times the index)
    // ********************************************************
    localparam logic [15:0] IDX_DRV_OFF = 16'h188d;
    localparam logic [15:0] IDX_THERMAL = 16'h188e;
    localparam logic [15:0] IDX_PIN_LO = 16'h1890;
    localparam logic [15:0] IDX_PIN_MID = 16'h1891;
    localparam logic [15:0] IDX_PIN_HI = 16'h1892;
    localparam logic [15:0] IDX_LOG_NE = 16'h1895;
    localparam logic [15:0] IDX_LOG_FULL = 16'h1896;
    localparam logic [15:0] IDX_LOG_WM = 16'h1897;
    localparam logic [15:0] IDX_DMA = 16'h1898;
    localparam logic [15:0] IDX_BUSY = 16'h189d;
    localparam logic [15:0] IDX_SYS_LATCH = 16'h1900;
    localparam logic [15:0] IDX_LOOP_LATCH = 16'h1901;
    localparam logic [15:0] IDX_ACC_LATCH = 16'h1905;
    localparam logic [15:0] IDX_JACK_LATCH = 16'h1906;
    localparam logic [15:0] IDX_CONV_LATCH = 16'h1908;
    localparam logic [15:0] IDX_REQ_LATCH = 16'h190a;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int BIT_THERM_WARN = 2;
    localparam int BIT_THERM_LIMIT = 1;
    localparam int BIT_SHUTDOWN = 0;
    localparam int BIT_CLASH = 15;
    localparam int BIT_HOSTERR = 12;
    localparam int BIT_CLKFAIL = 9;
    localparam int BIT_BOOT = 7;
    localparam int BIT_LOOP_LO = 8;
    localparam int BIT_ACC = 8;
    localparam int BIT_PHONES = 0;
    localparam int BIT_CLAMP_FALL = 5;
    localparam int BIT_CLAMP_RISE = 4;
    localparam int BIT_JACK2_FALL = 3;
    localparam int BIT_JACK2_RISE = 2;
    localparam int BIT_JACK1_FALL = 1;
    localparam int BIT_JACK1_RISE = 0;
    localparam int BIT_CONV_LO = 8;
    localparam int BIT_RANGE_LO = 0;

    localparam int REG_W = 16;
    localparam int PIN_HI_W = 8;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // ********************************************************
    // Carriers
    // ********************************************************
    typedef struct packed {
        logic [7:0] drv_off_done;   // Spk R/L, phones 3R..1L
        logic spk_thermal_warning;
        logic spk_thermal_limit;
        logic spk_shutdown_done;
        logic [39:0] pin_level;
        logic [7:0] log_has_entries;
        logic [7:0] log_full_flag;
        logic [7:0] log_level_reached;
        logic [6:0] proc_transfers_done;
        logic [6:0] proc_active;
    } rsel_raw_t;

    typedef struct packed {
        logic shared_memory_clash;
        logic host_port_error;
        logic main_clock_failure;
        logic startup_finished;
        logic [2:0] loop_lock;
        logic accessory_event;      // One-cycle detection pulse
        logic phones_detect_done;
        logic clamp_active;
        logic jack2;
        logic jack1;
        logic [3:0] converter_lock; // C2I2, C2I1, C1I2, C1I1
        logic [1:0] range_ctrl_signal;
        logic [15:0] proc_request;
    } rsel_evt_t;

endpackage

// ---- src/rsel_bank.sv ----
/*
 * Raw status registers and write-one-to-clear latches, edge-detected except the level-set accessory event bit.
 * Assumes sources synchronous to clk_i and a classic Wishbone master.
 */
// Operation
// - Driver disable-done bits read 0 while sequence runs, 1 when done.
// - Thermal bit 2 reads 1 while warning threshold exceeded.
// - Thermal bit 1 reads 1 while shutdown threshold exceeded.
// - Thermal bit 0 reads 1 once speaker shutdown has completed.
// - Pins 1..40 read over three registers, pin n at bit (n-1) mod 16.
// - Log not-empty bit n-1 reads 1 while log n has entries.
// - Log full bit n-1 reads 1 while log n is full.
// - Log watermark bit n-1 reads 1 while level reached.
// - DMA bit n-1 reads 1 when processor buffers are all done.
// - Busy bit n-1 reads 1 while processor n is busy.
// - Writing 1 to a latch bit clears it.
// - Bit 15 of system latch sets on memory clash rising edge.
// - System latch bits 12, 9, 7 set on rising edges.
// - Loop lock latches bits 10..8 set on both edges.
// - Bit 8 sets on accessory event; bit 0 on phones-detect rise.
// - Clamp bit 5 sets on falling, bit 4 on rising edge.
// - Jack 2 fall/rise at bits 3/2, jack 1 at bits 1/0.
// - Converter lock bits 11..8 set on both edges.
// - Range controller signal bits 1, 0 set on both edges.
// - Request n sets bit n-1 on rising edge.
`timescale 1ns/1ps

module rsel_bank #(
    parameter int ADR_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire rsel_pkg::rsel_raw_t raw_i,
    input wire rsel_pkg::rsel_evt_t evt_i
);

    // ********************************************************
    // Raw status capture
    // ********************************************************
    rsel_pkg::rsel_raw_t raw;

    // Registered so reads see a stable sample; writes never touch it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            raw <= '0;
        end else if (ce_i) begin
            raw <= raw_i;
        end
    end

    // ********************************************************
    // Edge detection
    // ********************************************************
    rsel_pkg::rsel_evt_t evt_q;
    rsel_pkg::rsel_evt_t rise;
    rsel_pkg::rsel_evt_t fall;

    // Previous copy of every source
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_q <= '0;
        end else if (ce_i) begin
            evt_q <= evt_i;
        end
    end

    assign rise = evt_i & ~evt_q;
    assign fall = ~evt_i & evt_q;

    // Set vectors of each latch register
    logic [15:0] set_sys;
    logic [15:0] set_loop;
    logic [15:0] set_acc;
    logic [15:0] set_jack;
    logic [15:0] set_conv;
    logic [15:0] set_req;

    // Map sources onto latch bit positions
    always_comb begin
        set_sys = '0;
        set_sys[rsel_pkg::BIT_CLASH] = rise.shared_memory_clash;
        set_sys[rsel_pkg::BIT_HOSTERR] = rise.host_port_error;
        set_sys[rsel_pkg::BIT_CLKFAIL] = rise.main_clock_failure;
        set_sys[rsel_pkg::BIT_BOOT] = rise.startup_finished;
        set_loop = '0;
        set_loop[rsel_pkg::BIT_LOOP_LO +: 3] =
            rise.loop_lock | fall.loop_lock;
        set_acc = '0;
        // Pulse source: any high cycle is an event, no edge needed
        set_acc[rsel_pkg::BIT_ACC] = evt_i.accessory_event;
        set_acc[rsel_pkg::BIT_PHONES] = rise.phones_detect_done;
        set_jack = '0;
        set_jack[rsel_pkg::BIT_CLAMP_FALL] = fall.clamp_active;
        set_jack[rsel_pkg::BIT_CLAMP_RISE] = rise.clamp_active;
        set_jack[rsel_pkg::BIT_JACK2_FALL] = fall.jack2;
        set_jack[rsel_pkg::BIT_JACK2_RISE] = rise.jack2;
        set_jack[rsel_pkg::BIT_JACK1_FALL] = fall.jack1;
        set_jack[rsel_pkg::BIT_JACK1_RISE] = rise.jack1;
        set_conv = '0;
        set_conv[rsel_pkg::BIT_CONV_LO +: 4] =
            rise.converter_lock | fall.converter_lock;
        set_conv[rsel_pkg::BIT_RANGE_LO +: 2] =
            rise.range_ctrl_signal | fall.range_ctrl_signal;
        set_req = rise.proc_request;
    end

    // ********************************************************
    // Bus decode
    // ********************************************************
    logic req;
    logic wr_hit;
    logic [15:0] wmask;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_hit = req && wb_we_i;
    // Only lanes 0 and 1 carry register bits
    assign wmask = wb_dat_i[15:0] & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Clear vector for one latch index
    function automatic logic [15:0] clr_for(input logic [15:0] idx);
        clr_for = (wr_hit && wb_adr_i == idx[ADR_W-1:0]) ? wmask : '0;
    endfunction

    // ********************************************************
    // Latch registers
    // ********************************************************
    localparam int NLATCH = 6;
    localparam logic [15:0] LATCH_IDX [NLATCH] = '{
        rsel_pkg::IDX_SYS_LATCH, rsel_pkg::IDX_LOOP_LATCH,
        rsel_pkg::IDX_ACC_LATCH, rsel_pkg::IDX_JACK_LATCH,
        rsel_pkg::IDX_CONV_LATCH, rsel_pkg::IDX_REQ_LATCH};

    logic [15:0] set_v [NLATCH];
    logic [15:0] latch [NLATCH];

    assign set_v[0] = set_sys;
    assign set_v[1] = set_loop;
    assign set_v[2] = set_acc;
    assign set_v[3] = set_jack;
    assign set_v[4] = set_conv;
    assign set_v[5] = set_req;

    // One sticky register per index; set wins so no event is lost
    for (genvar g = 0; g < NLATCH; g++) begin : g_latch
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                latch[g] <= rsel_pkg::REG_RESET;
            end else if (ce_i) begin
                latch[g] <= (latch[g] & ~clr_for(LATCH_IDX[g]))
                    | set_v[g];
            end
        end
    end

    // ********************************************************
    // Read mux and acknowledge
    // ********************************************************
    logic [15:0] next_rd;

    // Unmapped indices read zero and still acknowledge
    always_comb begin
        next_rd = '0;
        case (wb_adr_i)
            rsel_pkg::IDX_DRV_OFF[ADR_W-1:0]:
                next_rd = {8'h00, raw.drv_off_done};
            rsel_pkg::IDX_THERMAL[ADR_W-1:0]: begin
                next_rd[rsel_pkg::BIT_THERM_WARN] =
                    raw.spk_thermal_warning;
                next_rd[rsel_pkg::BIT_THERM_LIMIT] =
                    raw.spk_thermal_limit;
                next_rd[rsel_pkg::BIT_SHUTDOWN] = raw.spk_shutdown_done;
            end
            rsel_pkg::IDX_PIN_LO[ADR_W-1:0]:
                next_rd = raw.pin_level[15:0];
            rsel_pkg::IDX_PIN_MID[ADR_W-1:0]:
                next_rd = raw.pin_level[31:16];
            rsel_pkg::IDX_PIN_HI[ADR_W-1:0]:
                next_rd = {8'h00, raw.pin_level[39:32]};
            rsel_pkg::IDX_LOG_NE[ADR_W-1:0]:
                next_rd = {8'h00, raw.log_has_entries};
            rsel_pkg::IDX_LOG_FULL[ADR_W-1:0]:
                next_rd = {8'h00, raw.log_full_flag};
            rsel_pkg::IDX_LOG_WM[ADR_W-1:0]:
                next_rd = {8'h00, raw.log_level_reached};
            rsel_pkg::IDX_DMA[ADR_W-1:0]:
                next_rd = {9'h000, raw.proc_transfers_done};
            rsel_pkg::IDX_BUSY[ADR_W-1:0]:
                next_rd = {9'h000, raw.proc_active};
            rsel_pkg::IDX_SYS_LATCH[ADR_W-1:0]: next_rd = latch[0];
            rsel_pkg::IDX_LOOP_LATCH[ADR_W-1:0]: next_rd = latch[1];
            rsel_pkg::IDX_ACC_LATCH[ADR_W-1:0]: next_rd = latch[2];
            rsel_pkg::IDX_JACK_LATCH[ADR_W-1:0]: next_rd = latch[3];
            rsel_pkg::IDX_CONV_LATCH[ADR_W-1:0]: next_rd = latch[4];
            rsel_pkg::IDX_REQ_LATCH[ADR_W-1:0]: next_rd = latch[5];
            default: next_rd = '0;
        endcase
    end

    // One-cycle answer; ack drops the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else if (ce_i) begin
            wb_ack_o <= req;
            wb_dat_o <= req ? {16'h0000, next_rd} : '0;
        end
    end

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);

    // Edges judged against the held copy, which ce_i freezes as well
    a_clash_sets: assert property (
        (evt_i.shared_memory_clash && !evt_q.shared_memory_clash)
        |=> latch[0][rsel_pkg::BIT_CLASH])
        else $error("clash edge did not set latch");
    a_boot_sets: assert property (
        (evt_i.startup_finished && !evt_q.startup_finished)
        |=> latch[0][rsel_pkg::BIT_BOOT])
        else $error("boot edge did not set latch");
    a_loop_both_edges: assert property (
        (evt_i.loop_lock[0] != evt_q.loop_lock[0])
        |=> latch[1][rsel_pkg::BIT_LOOP_LO])
        else $error("loop lock edge missed");
    a_clamp_fall: assert property (
        (!evt_i.clamp_active && evt_q.clamp_active)
        |=> latch[3][rsel_pkg::BIT_CLAMP_FALL])
        else $error("clamp fall missed");
    a_jack1_rise: assert property (
        (evt_i.jack1 && !evt_q.jack1) |=> latch[3][rsel_pkg::BIT_JACK1_RISE])
        else $error("jack1 rise missed");
    a_req_maps: assert property (
        (evt_i.proc_request[15] && !evt_q.proc_request[15])
        |=> latch[5][15])
        else $error("request 16 not at bit 15");
    a_clear_works: assert property (
        (wr_hit && wb_adr_i == rsel_pkg::IDX_REQ_LATCH[ADR_W-1:0]
         && wmask[0] && !set_req[0]) |=> !latch[5][0])
        else $error("write one did not clear");
    a_no_spurious: assert property (
        (!latch[5][3] && !set_req[3]) |=> !latch[5][3])
        else $error("latch set without edge");
    a_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    a_busy_read: assert property (
        (req && !wb_we_i && wb_adr_i == rsel_pkg::IDX_BUSY[ADR_W-1:0])
        |=> wb_dat_o[6:0] == $past(raw.proc_active))
        else $error("busy readback wrong");

    // ********************************************************
    // Raw readback checks
    // ********************************************************
    // Read data is the copy registered one cycle before the answer
    logic rd_req;

    assign rd_req = req && !wb_we_i;

    a_drv_read: assert property (
        (rd_req && wb_adr_i == rsel_pkg::IDX_DRV_OFF[ADR_W-1:0])
        |=> wb_dat_o[7:0] == $past(raw.drv_off_done))
        else $error("driver status readback wrong");
    a_warn_read: assert property (
        (rd_req && wb_adr_i == rsel_pkg::IDX_THERMAL[ADR_W-1:0])
        |=> wb_dat_o[rsel_pkg::BIT_THERM_WARN]
            == $past(raw.spk_thermal_warning))
        else $error("thermal warning readback wrong");
    a_limit_read: assert property (
        (rd_req && wb_adr_i == rsel_pkg::IDX_THERMAL[ADR_W-1:0])
        |=> wb_dat_o[rsel_pkg::BIT_THERM_LIMIT]
            == $past(raw.spk_thermal_limit))
        else $error("thermal limit readback wrong");
    a_shutdown_read: assert property (
        (rd_req && wb_adr_i == rsel_pkg::IDX_THERMAL[ADR_W-1:0])
        |=> wb_dat_o[rsel_pkg::BIT_SHUTDOWN]
            == $past(raw.spk_shutdown_done))
        else $error("shutdown readback wrong");
    a_pin_low_read: assert property (
        (rd_req && wb_adr_i == rsel_pkg::IDX_PIN_LO[ADR_W-1:0])
        |=> wb_dat_o[15:0] == $past(raw.pin_level[15:0]))
        else $error("low pin readback wrong");
    a_pin_mid_read: assert property (
        (rd_req && wb_adr_i == rsel_pkg::IDX_PIN_MID[ADR_W-1:0])
        |=> wb_dat_o[15:0] == $past(raw.pin_level[31:16]))
        else $error("mid pin readback wrong");
    a_pin_high_read: assert property (
        (rd_req && wb_adr_i == rsel_pkg::IDX_PIN_HI[ADR_W-1:0])
        |=> wb_dat_o[15:0] == {8'h00, $past(raw.pin_level[39:32])})
        else $error("high pin readback wrong");
    a_log_ne_read: assert property (
        (rd_req && wb_adr_i == rsel_pkg::IDX_LOG_NE[ADR_W-1:0])
        |=> wb_dat_o[7:0] == $past(raw.log_has_entries))
        else $error("log not-empty readback wrong");
    a_log_full_read: assert property (
        (rd_req && wb_adr_i == rsel_pkg::IDX_LOG_FULL[ADR_W-1:0])
        |=> wb_dat_o[7:0] == $past(raw.log_full_flag))
        else $error("log full readback wrong");
    a_log_wm_read: assert property (
        (rd_req && wb_adr_i == rsel_pkg::IDX_LOG_WM[ADR_W-1:0])
        |=> wb_dat_o[7:0] == $past(raw.log_level_reached))
        else $error("log watermark readback wrong");
    a_dma_read: assert property (
        (rd_req && wb_adr_i == rsel_pkg::IDX_DMA[ADR_W-1:0])
        |=> wb_dat_o[6:0] == $past(raw.proc_transfers_done))
        else $error("dma readback wrong");

    // Upper half carries no register bits
    a_upper_zero: assert property (
        wb_dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");

    // ********************************************************
    // Latch set checks
    // ********************************************************
    // One per source kind; a wrong bit map shows up here first
    a_hosterr_sets: assert property (
        (evt_i.host_port_error && !evt_q.host_port_error)
        |=> latch[0][rsel_pkg::BIT_HOSTERR])
        else $error("host error edge missed");
    a_clkfail_sets: assert property (
        (evt_i.main_clock_failure && !evt_q.main_clock_failure)
        |=> latch[0][rsel_pkg::BIT_CLKFAIL])
        else $error("clock failure edge missed");
    a_loop3_edge: assert property (
        (evt_i.loop_lock[2] != evt_q.loop_lock[2])
        |=> latch[1][rsel_pkg::BIT_LOOP_LO + 2])
        else $error("loop 3 lock edge missed");
    a_acc_sets: assert property (
        evt_i.accessory_event |=> latch[2][rsel_pkg::BIT_ACC])
        else $error("accessory event missed");
    a_phones_rise: assert property (
        (evt_i.phones_detect_done && !evt_q.phones_detect_done)
        |=> latch[2][rsel_pkg::BIT_PHONES])
        else $error("phones detect edge missed");
    a_clamp_rise: assert property (
        (evt_i.clamp_active && !evt_q.clamp_active)
        |=> latch[3][rsel_pkg::BIT_CLAMP_RISE])
        else $error("clamp rise missed");
    a_jack2_fall: assert property (
        (!evt_i.jack2 && evt_q.jack2)
        |=> latch[3][rsel_pkg::BIT_JACK2_FALL])
        else $error("jack2 fall missed");
    a_jack2_rise: assert property (
        (evt_i.jack2 && !evt_q.jack2)
        |=> latch[3][rsel_pkg::BIT_JACK2_RISE])
        else $error("jack2 rise missed");
    a_conv_edges: assert property (
        (evt_i.converter_lock[3] != evt_q.converter_lock[3])
        |=> latch[4][rsel_pkg::BIT_CONV_LO + 3])
        else $error("converter lock edge missed");
    a_range_edges: assert property (
        (evt_i.range_ctrl_signal[1] != evt_q.range_ctrl_signal[1])
        |=> latch[4][rsel_pkg::BIT_RANGE_LO + 1])
        else $error("range signal edge missed");

    // Every taken request is answered on the next edge
    a_ack_follows: assert property (
        req |=> wb_ack_o)
        else $error("request not answered");

    c_clear: cover property (wr_hit && wmask != '0);
    c_set_clear: cover property (|(set_req & clr_for(rsel_pkg::IDX_REQ_LATCH)));
    c_read: cover property (req && !wb_we_i);
    c_loop_fall: cover property (fall.loop_lock[2]);
    c_acc_event: cover property (set_acc[rsel_pkg::BIT_ACC]);

endmodule // rsel_bank

// ---- test/rsel_bank_bench.sv ----
/*
 * Self-checking bench for the raw status and event latch bank.
 * Assumes rsel_pkg is compiled first and the bank answers one cycle
 * after a classic Wishbone request is taken.
 */
`timescale 1ns/1ps

module rsel_bank_bench;
    localparam int RAW_W = $bits(rsel_pkg::rsel_raw_t);
    localparam int EVT_W = $bits(rsel_pkg::rsel_evt_t);
    localparam int LIMIT = 10000;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [15:0] wb_adr_i = 16'h0000;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    rsel_pkg::rsel_raw_t raw_i = '0;
    rsel_pkg::rsel_evt_t evt_i = '0;
    rsel_pkg::rsel_evt_t prev;
    rsel_pkg::rsel_evt_t nxt;
    int n_fail = 0;
    int checks = 0;
    int cycles = 0;
    int seed = 69;
    int i;
    int j;
    int k;
    logic [95:0] r96;
    logic [31:0] rd;
    logic [31:0] e;
    logic [31:0] m;
    logic [3:0] s;
    // Raw registers first, then latches, then one unmapped hole
    logic [15:0] idx_tab [0:16] = '{rsel_pkg::IDX_DRV_OFF,
        rsel_pkg::IDX_THERMAL, rsel_pkg::IDX_PIN_LO, rsel_pkg::IDX_PIN_MID,
        rsel_pkg::IDX_PIN_HI, rsel_pkg::IDX_LOG_NE, rsel_pkg::IDX_LOG_FULL,
        rsel_pkg::IDX_LOG_WM, rsel_pkg::IDX_DMA, rsel_pkg::IDX_BUSY,
        rsel_pkg::IDX_SYS_LATCH, rsel_pkg::IDX_LOOP_LATCH,
        rsel_pkg::IDX_ACC_LATCH, rsel_pkg::IDX_JACK_LATCH,
        rsel_pkg::IDX_CONV_LATCH, rsel_pkg::IDX_REQ_LATCH, 16'h1899};

    rsel_bank rsel_bank_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .raw_i(raw_i),
        .evt_i(evt_i));

    // 100 MHz clock and a hang guard
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_fail++;
            $display("[FAIL] %0t timeout", $time);
            conclude();
        end
    end

    // ********************************************************
    // Expectations
    // ********************************************************
    function automatic logic [31:0] exp_raw(input logic [15:0] a,
                                            input rsel_pkg::rsel_raw_t r);
        case (a)
            rsel_pkg::IDX_DRV_OFF: return {24'h0, r.drv_off_done};
            rsel_pkg::IDX_THERMAL: return {29'h0, r.spk_thermal_warning,
                r.spk_thermal_limit, r.spk_shutdown_done};
            rsel_pkg::IDX_PIN_LO: return {16'h0, r.pin_level[15:0]};
            rsel_pkg::IDX_PIN_MID: return {16'h0, r.pin_level[31:16]};
            rsel_pkg::IDX_PIN_HI: return {24'h0, r.pin_level[39:32]};
            rsel_pkg::IDX_LOG_NE: return {24'h0, r.log_has_entries};
            rsel_pkg::IDX_LOG_FULL: return {24'h0, r.log_full_flag};
            rsel_pkg::IDX_LOG_WM: return {24'h0, r.log_level_reached};
            rsel_pkg::IDX_DMA: return {25'h0, r.proc_transfers_done};
            rsel_pkg::IDX_BUSY: return {25'h0, r.proc_active};
            default: return 32'h0;
        endcase
    endfunction

    // Latch image after one step from p to n, from a cleared bank
    function automatic logic [31:0] exp_lat(input logic [15:0] a,
        input rsel_pkg::rsel_evt_t p, input rsel_pkg::rsel_evt_t n);
        rsel_pkg::rsel_evt_t up;
        rsel_pkg::rsel_evt_t dn;
        rsel_pkg::rsel_evt_t x;
        up = rsel_pkg::rsel_evt_t'(~p & n);
        dn = rsel_pkg::rsel_evt_t'(p & ~n);
        x = rsel_pkg::rsel_evt_t'(p ^ n);
        case (a)
            rsel_pkg::IDX_SYS_LATCH: return {16'h0, up.shared_memory_clash,
                2'b00, up.host_port_error, 2'b00, up.main_clock_failure,
                1'b0, up.startup_finished, 7'h0};
            rsel_pkg::IDX_LOOP_LATCH: return {21'h0, x.loop_lock, 8'h0};
            rsel_pkg::IDX_ACC_LATCH: return {23'h0, n.accessory_event,
                7'h0, up.phones_detect_done};
            rsel_pkg::IDX_JACK_LATCH: return {26'h0, dn.clamp_active,
                up.clamp_active, dn.jack2, up.jack2, dn.jack1, up.jack1};
            rsel_pkg::IDX_CONV_LATCH: return {20'h0, x.converter_lock,
                6'h0, x.range_ctrl_signal};
            rsel_pkg::IDX_REQ_LATCH: return {16'h0, up.proc_request};
            default: return 32'h0;
        endcase
    endfunction

    // ********************************************************
    // Bus cycles and comparison
    // ********************************************************
    // Entered just after an edge; leaves one idle cycle behind it
    task automatic xfer(input logic we, input logic [15:0] adr,
                        input logic [31:0] dat, output logic [31:0] q);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        // No limit of its own: only the cycle guard ends a wait
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd_chk(input logic [15:0] adr, input logic [31:0] x);
        logic [31:0] q;
        xfer(1'b0, adr, 32'h0, q);
        checks++;
        if (q !== x) begin
            n_fail++;
            $display("[FAIL] %0t at %h got %h want %h", $time, adr, q, x);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (i = 0; i < 17; i++) rd_chk(idx_tab[i], 32'h0);
        $display("test reset_values done");
        // Frozen bank must miss a pulse and hold off a pending read
        ce_i <= 1'b0;
        evt_i.jack1 <= 1'b1;
        fork
            rd_chk(rsel_pkg::IDX_JACK_LATCH, 32'h0);
            begin
                @(posedge clk_i);
                evt_i.jack1 <= 1'b0;
                repeat (2) @(posedge clk_i);
                ce_i <= 1'b1;
            end
        join
        $display("test clock_enable done");
        // Random status words, all ones first as a corner
        for (k = 0; k < 12; k++) begin
            r96 = {$random(seed), $random(seed), $random(seed)};
            if (k == 0) r96 = '1;
            // Every pin is taken as a plain input, so all pin bits count
            raw_i <= rsel_pkg::rsel_raw_t'(r96[RAW_W-1:0]);
            repeat (2) @(posedge clk_i);
            for (i = 0; i < 11; i++) begin
                j = (i == 10) ? 16 : i;
                rd_chk(idx_tab[j], exp_raw(idx_tab[j], raw_i));
            end
            xfer(1'b1, idx_tab[k % 10], 32'hffffffff, rd);
            rd_chk(idx_tab[k % 10], exp_raw(idx_tab[k % 10], raw_i));
        end
        $display("test raw_status done");
        // All rise, then all fall, then random steps
        for (k = 0; k < 24; k++) begin
            r96 = {$random(seed), $random(seed), $random(seed)};
            prev = evt_i;
            nxt = rsel_pkg::rsel_evt_t'(r96[EVT_W-1:0]);
            if (k < 2) nxt = (k == 0) ? '1 : '0;
            evt_i <= nxt;
            @(posedge clk_i);
            evt_i.accessory_event <= 1'b0;
            for (i = 10; i < 16; i++) begin
                e = exp_lat(idx_tab[i], prev, nxt);
                rd_chk(idx_tab[i], e);
                m = {16'h0, 16'($random(seed))};
                // Random lanes: only selected low bytes may clear
                s = 4'($random(seed));
                wb_sel_i <= s;
                xfer(1'b1, idx_tab[i], m, rd);
                wb_sel_i <= 4'hf;
                m = m & {16'h0, {8{s[1]}}, {8{s[0]}}};
                rd_chk(idx_tab[i], e & ~m);
                xfer(1'b1, idx_tab[i], 32'h0000ffff, rd);
                rd_chk(idx_tab[i], 32'h0);
            end
        end
        $display("test latches done");
        // Edge landing on the clearing edge must survive
        evt_i.proc_request <= 16'h0000;
        @(posedge clk_i);
        xfer(1'b1, rsel_pkg::IDX_REQ_LATCH, 32'h0000ffff, rd);
        evt_i.proc_request <= 16'h8001;
        xfer(1'b1, rsel_pkg::IDX_REQ_LATCH, 32'h0000ffff, rd);
        rd_chk(rsel_pkg::IDX_REQ_LATCH, 32'h00008001);
        $display("test set_beats_clear done");
        // Second reset with latches and status busy
        evt_i <= '1;
        raw_i <= '1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b1;
        evt_i <= '0;
        raw_i <= '0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (i = 0; i < 17; i++) rd_chk(idx_tab[i], 32'h0);
        $display("test second_reset done");
        conclude();
    end
endmodule // rsel_bank_bench
